//--- dv/pts_timer_bench.sv
// self-checking bench for the period timer with scalers
`include "pts_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module pts_timer_bench;
  import pts_pkg::*;
  localparam logic [4:0] A_CNT = `PTS_OFS_COUNT;
  localparam logic [4:0] A_PER = `PTS_OFS_PERIOD;
  localparam logic [4:0] A_CTL = `PTS_OFS_CONTROL;
  localparam logic [4:0] A_STA = `PTS_OFS_IRQ_STAT;
  localparam logic [4:0] A_ENA = `PTS_OFS_IRQ_EN;
  logic          clock_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic          cyc     = 1'b0;
  logic          stb     = 1'b0;
  logic          we      = 1'b0;
  logic [4:0]    adr     = 5'h00;
  logic [3:0]    sel     = 4'h0;
  logic [31:0]   dat     = 32'h0;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  logic          irq_o;
  logic          ssp_match_o;
  pts_tbase_type tbase;
  logic [31:0]   rd;
  int            n_fail = 0;
  int            cmp_count = 0;
  int            gap;
  pts_timer u_pts_timer (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .pwm_tbase_o(tbase), .ssp_match_o(ssp_match_o));
  always #4 clock_i = ~clock_i;
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task xfer(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    @(posedge clock_i);
    while (wb_ack_o !== 1'b1) @(posedge clock_i);
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task rd_chk(input logic [4:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    check(rd, e);
  endtask
  task wait_pulse;
    @(posedge clock_i);
    while (ssp_match_o !== 1'b1) @(posedge clock_i);
    check({31'h0, tbase.match}, 32'h1);
  endtask
  task gap_len;
    wait_pulse();
    gap = 0;
    do begin
      @(posedge clock_i);
      gap++;
    end while (ssp_match_o !== 1'b1 && gap < 2000);
  endtask
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk(A_CNT, 32'h00);
    rd_chk(A_PER, 32'hFF);
    rd_chk(A_CTL, 32'h00);
    rd_chk(A_STA, 32'h00);
    rd_chk(5'h02, 32'h00);
    rd_chk(A_ENA, 32'h00);
    $display("test reset values done");
    xfer(1'b1, A_PER, 32'h3, 4'hE);
    rd_chk(A_PER, 32'hFF);
    wr(A_PER, 32'h3);
    rd_chk(A_PER, 32'h3);
    wr(A_CNT, 32'h5);
    rd_chk(A_CNT, 32'h5);
    wr(A_CTL, 32'h8);
    rd_chk(A_CNT, 32'h5);
    repeat (40) @(posedge clock_i);
    rd_chk(A_CNT, 32'h5);
    $display("test count access done");
    for (int p = 0; p < 4; p++) begin
      wr(A_CNT, 32'h0);
      wr(A_CTL, 32'hC | p);
      gap_len();
      check(gap, 16 * (p == 0 ? 1 : (p == 1 ? 4 : 16)));
    end
    $display("test prescale done");
    wr(A_STA, 32'h2);
    wr(A_CTL, 32'hC);
    wait_pulse();
    wr(A_CNT, 32'h0);
    wait_pulse();
    rd_chk(A_STA, 32'h0);
    wait_pulse();
    repeat (2) @(posedge clock_i);
    rd_chk(A_STA, 32'h2);
    check({31'h0, irq_o}, 32'h0);
    wr(A_STA, 32'h2);
    rd_chk(A_STA, 32'h0);
    wr(A_ENA, 32'h2);
    wr(A_CNT, 32'h0);
    wait_pulse();
    check({31'h0, irq_o}, 32'h0);
    wait_pulse();
    repeat (2) @(posedge clock_i);
    check({31'h0, irq_o}, 32'h1);
    wr(A_STA, 32'h2);
    repeat (2) @(posedge clock_i);
    check({31'h0, irq_o}, 32'h0);
    $display("test postscale done");
    final_report();
  end
endmodule
`default_nettype wire

//--- logic/pts_cfg.svh
// register offsets, field positions, reset values and timing counts of the period timer
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
`define PTS_OFS_COUNT      5'h00
`define PTS_OFS_PERIOD     5'h04
`define PTS_OFS_CONTROL    5'h08
`define PTS_OFS_IRQ_STAT   5'h0C
`define PTS_OFS_IRQ_EN     5'h10
`define PTS_ADR_W          5
`define PTS_PRE_LO         0
`define PTS_PRE_HI         1
`define PTS_RUN_BIT        2
`define PTS_POST_LO        3
`define PTS_POST_HI        6
`define PTS_IRQ_BIT        1
`define PTS_COUNT_RST      8'h00
`define PTS_PERIOD_RST     8'hFF
`define PTS_CONTROL_RST    7'h00
`define PTS_INSTR_DIV      2'h3
`define PTS_PRE4_LAST      4'h3
`define PTS_PRE16_LAST     4'hF
`endif

//--- logic/pts_pkg.sv
// types of the period timer with scalers
package pts_pkg;
  // packed msb first: postscale 6:3, run 2, prescale 1:0
  typedef struct packed {
    logic [3:0] postscale;
    logic       timer_run;
    logic [1:0] prescale_select;
  } pts_control_type;
  typedef struct packed {
    logic [7:0] count;
    logic       match;
  } pts_tbase_type;
  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } pts_wbo_type;
endpackage

//--- logic/pts_timer.sv
// period timer with prescaler, postscaler, wishbone registers and interrupt
//
// Notes on behaviour
// [R1] 8-bit up-counter between prescaler and postscaler; readable, writable, cleared on reset.
// [R2] counter ticks at clock over four; control bits 1:0 pick prescale 1, 4 or 16.
// [R3] counter runs from 00h to period value, then wraps to 00h next tick.
// [R4] period register readable and writable, reset to FFh.
// [R5] matches pass a 4-bit postscaler, 1 to 16, which sets the match flag bit 1.
// [R6] clearing the run bit, control bit 2, stops the counter.
// [R7] scalers clear on count write, control write, and reset.
// [R8] control write keeps the count value.
// [R9] count and match go to the PWM unit as time base.
// [R10] pre-postscaler match goes to the serial port for its shift clock.
// [R11] prescale field 00 is 1, 01 is 4, 1x is 16.
// [R12] postscale field holds N minus one; reset to zero.
`include "pts_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module pts_timer (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [4:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq_o,
  output pts_pkg::pts_tbase_type    pwm_tbase_o,
  output logic                      ssp_match_o
);
  import pts_pkg::*;

  typedef struct packed {
    logic [1:0]      div4;
    logic [3:0]      pre;
    logic [3:0]      post;
    logic [7:0]      count;
    logic [7:0]      period;
    pts_control_type ctl;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_en;
    pts_wbo_type     wbo;
    logic            irq;
    pts_tbase_type   tbase;
    logic            sync_serial_port;
  } pts_state_type;

  pts_state_type s_q;
  pts_state_type s_d;

  // last prescaler count for the selected ratio
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    if (sel[1]) begin
      pre_last = `PTS_PRE16_LAST; // R11
    end else if (sel[0]) begin
      pre_last = `PTS_PRE4_LAST;
    end else begin
      pre_last = 4'h0;
    end
  endfunction

  logic       req;
  logic       wr;
  logic       tick;
  logic       match;
  logic       post_out;
  logic [7:0] wbyte;

  assign req   = wb_cyc_i && wb_stb_i && !s_q.wbo.ack;
  assign wr    = req && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  always_comb begin
    s_d      = s_q;
    tick     = 1'b0;
    match    = 1'b0;
    post_out = 1'b0;
    s_d.div4 = s_q.div4 + 2'h1; // R2
    if (s_q.ctl.timer_run && s_q.div4 == `PTS_INSTR_DIV) begin // R6
      if (s_q.pre == pre_last(s_q.ctl.prescale_select)) begin
        s_d.pre = 4'h0;
        tick    = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 4'h1;
      end
    end
    if (tick) begin
      if (s_q.count == s_q.period) begin
        s_d.count = `PTS_COUNT_RST; // R3
        match     = 1'b1;
        if (s_q.post == s_q.ctl.postscale) begin // R12
          s_d.post = 4'h0;
          post_out = 1'b1; // R5
        end else begin
          s_d.post = s_q.post + 4'h1;
        end
      end else begin
        s_d.count = s_q.count + 8'h01; // R1
      end
    end
    s_d.wbo.ack = req;
    s_d.wbo.dat = 32'h0;
    if (req && !wb_we_i) begin
      if (wb_adr_i == `PTS_OFS_COUNT) begin
        s_d.wbo.dat[7:0] = s_q.count;
      end else if (wb_adr_i == `PTS_OFS_PERIOD) begin
        s_d.wbo.dat[7:0] = s_q.period;
      end else if (wb_adr_i == `PTS_OFS_CONTROL) begin
        s_d.wbo.dat[`PTS_POST_HI:0] = s_q.ctl;
      end else if (wb_adr_i == `PTS_OFS_IRQ_STAT) begin
        s_d.wbo.dat[1:0] = s_q.irq_stat;
      end else begin
        s_d.wbo.dat = 32'h0;
      end
    end
    if (post_out) begin
      s_d.irq_stat[`PTS_IRQ_BIT] = 1'b1; // R5
    end
    if (wr) begin
      if (wb_adr_i == `PTS_OFS_COUNT) begin
        s_d.count = wbyte; // R1
        s_d.pre   = 4'h0; // R7
        s_d.post  = 4'h0;
      end else if (wb_adr_i == `PTS_OFS_PERIOD) begin
        s_d.period = wbyte; // R4
      end else if (wb_adr_i == `PTS_OFS_CONTROL) begin
        s_d.ctl   = wbyte[`PTS_POST_HI:0]; // R8
        s_d.pre   = 4'h0; // R7
        s_d.post  = 4'h0;
      end else if (wb_adr_i == `PTS_OFS_IRQ_STAT) begin
        s_d.irq_stat = s_q.irq_stat & ~wbyte[1:0];
        if (post_out) begin
          s_d.irq_stat[`PTS_IRQ_BIT] = 1'b1;
        end
      end else if (wb_adr_i == `PTS_OFS_IRQ_EN) begin
        s_d.irq_en = wbyte[1:0];
      end
    end
    s_d.irq       = |(s_d.irq_stat & s_d.irq_en);
    s_d.tbase     = '{count: s_d.count, match: match}; // R9
    s_d.sync_serial_port       = match; // R10
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_q        <= '0;
      s_q.count  <= `PTS_COUNT_RST; // R1
      s_q.period <= `PTS_PERIOD_RST; // R4
      s_q.ctl    <= `PTS_CONTROL_RST; // R12
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o    = s_q.wbo.dat;
  assign wb_ack_o    = s_q.wbo.ack;
  assign irq_o       = s_q.irq;
  assign pwm_tbase_o = s_q.tbase;
  assign ssp_match_o = s_q.sync_serial_port;

  chk_period_wrap: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R3
    (tick && !wr && s_q.count == s_q.period) |=> (s_q.count == 8'h00 && s_q.sync_serial_port))
    else $error("count did not wrap on period match");
  chk_stop_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R6
    (!s_q.ctl.timer_run && !wr) |=> $stable(s_q.count))
    else $error("count moved while stopped");
  chk_ctl_keeps: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R8
    (wr && wb_adr_i == `PTS_OFS_CONTROL) |=> (s_q.count == $past(s_q.count) && s_q.pre == 4'h0))
    else $error("control write disturbed count");
  chk_cnt_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R7
    (wr && wb_adr_i == `PTS_OFS_COUNT) |=> (s_q.pre == 4'h0 && s_q.post == 4'h0))
    else $error("scalers not cleared on count write");
  chk_irq_sets: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R5
    post_out |=> s_q.irq_stat[`PTS_IRQ_BIT])
    else $error("flag not set by postscaler");
  chk_post_div: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R12
    post_out |-> (s_q.post == s_q.ctl.postscale && match))
    else $error("postscaler fired off count");
  chk_tick_rate: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R2
    tick |-> s_q.div4 == 2'h3)
    else $error("tick off instruction clock");
  chk_pre_range: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R11
    (s_q.ctl.prescale_select == 2'h0) |-> s_q.pre == 4'h0)
    else $error("prescaler counting at ratio one");
endmodule
`default_nettype wire
